// File: rtl/lssl_ahb_regs.sv
// AHB-Lite slave holding control and showing block state
`timescale 1ns/1ns
`default_nettype none
module lssl_ahb_regs
	import lssl_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	lssl_reg_if.regs         rif
);
	logic       ctrl_short;
	logic       wr_pend;
	logic [7:0] wr_addr;
	logic [31:0] status_word;
	logic [31:0] rd_word;
	wire        take     = hsel && hready && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD;
	wire [7:0]  a_addr   = haddr[7:0];
	wire        a_mapped = haddr[31:8] == 24'h000000;

	assign rif.short_en = ctrl_short;
	assign status_word  = {rif.err_status, rif.cfg_code, rif.out_latch, 7'h00,
		rif.mode_special};
	// Unmapped addresses read as zero and ignore writes
	assign rd_word = !a_mapped ? 32'h0000_0000 :
		a_addr == ADDR_CTRL   ? {31'h0000_0000, ctrl_short} :
		a_addr == ADDR_STATUS ? status_word :
		a_addr == ADDR_SHIFT  ? {24'h00_0000, rif.shift_word} : 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend   <= 1'b0;
			wr_addr   <= 8'h00;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			wr_pend <= take && hwrite && a_mapped;
			wr_addr <= a_addr;
			if (take && !hwrite) begin
				hrdata <= rd_word;
			end
		end
	end

	// Zero wait states, so write data lands one edge after the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_short <= CTRL_RST[0];
		end else if (wr_pend && wr_addr == ADDR_CTRL) begin
			ctrl_short <= hwdata[CTRL_SHORT_EN];
		end
	end
endmodule
`default_nettype wire

// File: rtl/lssl_pkg.sv
// Constants and types shared by the LED sink shift and latch block
package lssl_pkg;
	localparam int         CH_N          = 8;
	localparam int         GAIN_STEPS    = 256;
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_STATUS   = 8'h04;
	localparam logic [7:0] ADDR_SHIFT    = 8'h08;
	localparam int         CTRL_SHORT_EN = 0;
	localparam logic [0:0] CTRL_RST      = 1'h0;
	localparam int         ST_MODE_POS   = 0;
	localparam int         ST_LATCH_POS  = 8;
	localparam int         ST_CFG_POS    = 16;
	localparam int         ST_ERR_POS    = 24;
	localparam logic [7:0] LATCH_RST     = 8'h00;
	localparam logic [7:0] CFG_RST       = 8'h00;
	localparam logic [1:0] SW_EDGE4      = 2'h2;
	localparam logic [1:0] SW_EDGE5      = 2'h1;
	localparam logic [1:0] LOW_LOAD      = 2'h2;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam int         SYNC_W        = 37;
	typedef enum logic {MODE_NORMAL, MODE_SPECIAL} lssl_mode_e;
endpackage

// File: rtl/lssl_reg_if.sv
// Carrier between the register slave and the pin logic
`timescale 1ns/1ns
`default_nettype none
interface lssl_reg_if;
	logic       short_en;
	logic       mode_special;
	logic [7:0] out_latch;
	logic [7:0] cfg_code;
	logic [7:0] err_status;
	logic [7:0] shift_word;
	modport regs (output short_en, input mode_special, out_latch, cfg_code, err_status,
		shift_word);
	modport core (input short_en, output mode_special, out_latch, cfg_code, err_status,
		shift_word);
endinterface
`default_nettype wire

// File: rtl/lssl_top.sv
// Shift register, latches, mode switching and error status of the LED sink
//
// Behaviour
// - Eight-bit shift register feeds parallel latches
// - One-clock output-enable pulse starts mode switching
// - Normal mode shifts input, outputs leaving bit
// - Normal mode latch pin loads output latch
// - Channel sinks only when enabled and latched
// - Special mode enable low loads error status
// - Special mode latch pin loads configuration latch
// - Configuration code selects one of 256 gains
// - Open load: on and current ok reads 1
// - Optional short detect clears then restores bit
// - Global overtemperature turns all off, records all
// - Channel overtemperature turns that channel off only
// - Channels restart after cooling, error kept
// - Channel overtemperature errors stay sticky
// - Return to normal clears stored overtemperature errors
// - Fourth clock edge samples latch pin for mode
// - Status loads from third low enable sample
// - Starts in normal mode after reset
`timescale 1ns/1ns
`default_nettype none
module lssl_top
	import lssl_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        led_clk,
	input  wire logic        serial_in,
	input  wire logic        latch_mode_sel,
	input  wire logic        out_en_n_mode,
	input  wire logic [7:0]  cur_ok,
	input  wire logic [7:0]  short_trig,
	input  wire logic [7:0]  short_ret,
	input  wire logic        ot_global,
	input  wire logic [7:0]  ot_chan,
	output logic             serial_out,
	output logic      [7:0]  channel_sink,
	output logic      [7:0]  gain_code
);
	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [SYNC_W-1:0] sync_a;
	logic [SYNC_W-1:0] sync_b;
	wire  [SYNC_W-1:0] pins_raw = {led_clk, serial_in, latch_mode_sel, out_en_n_mode,
		cur_ok, short_trig, short_ret, ot_global, ot_chan};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= pins_raw;
			sync_b <= sync_a;
		end
	end

	wire       lclk_s  = sync_b[36];
	wire       sdi_s   = sync_b[35];
	wire       le_s    = sync_b[34];
	wire       oe_n_s  = sync_b[33];
	wire [7:0] ok_s    = sync_b[32:25];
	wire [7:0] trig_s  = sync_b[24:17];
	wire [7:0] ret_s   = sync_b[16:9];
	wire       otg_s   = sync_b[8];
	wire [7:0] otc_s   = sync_b[7:0];

	// Edge detect on the second stage only, one enable pulse per serial clock
	logic lclk_d;
	wire  clk_rise = lclk_s && !lclk_d;

	////////////////////////////////////////////////////////////////////////
	// State
	lssl_mode_e mode;
	logic [7:0] shift_reg;
	logic [7:0] out_latch;
	logic [7:0] cfg_latch;
	logic [7:0] err_ot;
	logic [7:0] short_err;
	logic [1:0] oe_hist;
	logic [1:0] sw_phase;
	logic [1:0] low_cnt;
	logic       short_en;

	lssl_reg_if rif ();

	lssl_ahb_regs u_regs (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.rif       (rif)
	);

	assign short_en         = rif.short_en;
	assign rif.mode_special = mode == MODE_SPECIAL;
	assign rif.out_latch    = out_latch;
	assign rif.cfg_code     = cfg_latch;
	assign rif.shift_word   = shift_reg;

	////////////////////////////////////////////////////////////////////////
	// Decoding
	wire special  = mode == MODE_SPECIAL;
	// high-then-low history, then a high sample, marks a one-clock pulse
	wire sw_pulse = clk_rise && oe_n_s && oe_hist == 2'b10;
	// Latch pin only picks the mode between third and fifth edges
	wire le_block = sw_pulse || sw_phase != 2'b00;
	wire do_latch = clk_rise && le_s && !le_block;
	wire sw_decide = clk_rise && sw_phase == SW_EDGE4;
	wire to_normal = sw_decide && !le_s;
	// third and later low samples load status
	wire err_load  = clk_rise && special && !oe_n_s && low_cnt >= LOW_LOAD;
	// Enable low stops serial input in special mode
	wire shift_hold = special && !oe_n_s;
	wire [7:0] chan_on = out_latch & {CH_N{!oe_n_s}};
	wire [7:0] err_status;
	wire [7:0] next_sink;
	wire [7:0] next_err_ot;
	wire [7:0] next_short;

	// open load, with any recorded error forcing 0
	assign err_status = chan_on & ok_s & ~short_err & ~err_ot;
	assign rif.err_status = err_status;
	// enable low and latch on, thermal cut, live
	assign next_sink = chan_on & ~{CH_N{otg_s}} & ~otc_s;
	// sticky, set wins over the clear
	assign next_err_ot = (to_normal ? 8'h00 : err_ot) | {CH_N{otg_s}} | (otc_s & chan_on);
	// trigger clears the status bit, return restores it
	assign next_short = !short_en ? 8'h00 :
		(short_err & ~ret_s) | (trig_s & chan_on);
	// next shift word, status load wins over serial input
	// Latches take this word, so a latch edge keeps the bit shifted in with it
	wire [7:0] shift_new = err_load ? err_status :
		(clk_rise && !shift_hold) ? {shift_reg[6:0], sdi_s} : shift_reg;

	////////////////////////////////////////////////////////////////////////
	// Mode and phase tracking
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lclk_d   <= 1'b0;
			mode     <= MODE_NORMAL;
			oe_hist  <= 2'b00;
			sw_phase <= 2'b00;
			low_cnt  <= 2'b00;
		end else begin
			lclk_d <= lclk_s;
			if (clk_rise) begin
				oe_hist  <= {oe_hist[0], oe_n_s};
				sw_phase <= sw_pulse ? SW_EDGE4 : sw_phase == SW_EDGE4 ? SW_EDGE5 : 2'b00;
				low_cnt  <= oe_n_s ? 2'b00 : low_cnt == 2'b11 ? low_cnt : low_cnt + 2'b01;
			end
			if (sw_decide) begin
				mode <= le_s ? MODE_SPECIAL : MODE_NORMAL;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shift register and latches
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			shift_reg <= 8'h00;
			out_latch <= LATCH_RST;
			cfg_latch <= CFG_RST;
		end else begin
			shift_reg <= shift_new;
			if (do_latch && !special) begin
				out_latch <= shift_new;
			end
			if (do_latch && special) begin
				cfg_latch <= shift_new;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Error records and registered pin outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			err_ot       <= 8'h00;
			short_err    <= 8'h00;
			serial_out   <= 1'b0;
			channel_sink <= 8'h00;
			gain_code    <= CFG_RST;
		end else begin
			err_ot       <= next_err_ot;
			short_err    <= next_short;
			serial_out   <= shift_reg[7];
			channel_sink <= next_sink;
			// code passed to the regulator, 256 gain steps
			gain_code    <= cfg_latch;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	chk_sink_gating: assert property (
		|channel_sink |-> !$past(oe_n_s) && (channel_sink & ~$past(out_latch)) == 8'h00)
		else $error("channel sinks without enable or latch");

	chk_global_cut: assert property (
		otg_s |=> channel_sink == 8'h00 && err_ot == 8'hff)
		else $error("global overtemperature did not cut and record");

	chk_chan_cut: assert property (
		otc_s[0] && !otg_s |=> !channel_sink[0])
		else $error("channel overtemperature did not cut its channel");

	chk_ot_sticky: assert property (
		err_ot[3] && !to_normal |=> err_ot[3])
		else $error("overtemperature record lost before normal mode");

	chk_normal_clear: assert property (
		to_normal && !otg_s && otc_s == 8'h00 |=> err_ot == 8'h00)
		else $error("return to normal kept error records");

	chk_mode_edge4: assert property (
		sw_decide |=> special == $past(le_s))
		else $error("mode not taken from fourth edge");

	chk_shift_normal: assert property (
		clk_rise && !special |=> shift_reg == {$past(shift_reg[6:0]), $past(sdi_s)})
		else $error("normal mode shift wrong");

	chk_latch_normal: assert property (
		clk_rise && le_s && !special && !le_block |=>
			out_latch == {$past(shift_reg[6:0]), $past(sdi_s)})
		else $error("output latch not loaded");

	chk_cfg_latch: assert property (
		do_latch && special |=> cfg_latch == shift_reg && $stable(out_latch))
		else $error("configuration latch load wrong");

	chk_err_load: assert property (
		clk_rise && special && !oe_n_s && low_cnt < LOW_LOAD |=> $stable(shift_reg))
		else $error("shift moved before status load");

	chk_status_load: assert property (
		err_load |=> shift_reg == $past(err_status))
		else $error("error status not loaded");

	// Sink, serial, status, short, latch, mode, gain, shift, overtemperature record and low count checks
	chk_sink_off: assert property (
		oe_n_s |=> channel_sink == 8'h00)
		else $error("channel sinks with enable high");

	chk_sink_restart: assert property (
		!otg_s && otc_s == 8'h00 |=> channel_sink == $past(chan_on))
		else $error("channel not back on after cooling");

	chk_serial_out: assert property (
		clk_rise && !special |-> ##2 serial_out == $past(shift_reg[6], 2))
		else $error("serial output not the leaving bit");

	chk_open_load: assert property (
		err_load |=> (shift_reg & ~($past(chan_on) & $past(ok_s))) == 8'h00)
		else $error("status bit set for off or open channel");

	chk_status_clean: assert property (
		err_load |=> (shift_reg & ($past(short_err) | $past(err_ot))) == 8'h00)
		else $error("status bit set despite recorded error");

	chk_short_set: assert property (
		short_en && trig_s[5] && chan_on[5] |=> short_err[5])
		else $error("short trigger not recorded");

	chk_short_ret: assert property (
		short_err[5] && ret_s[5] && !trig_s[5] |=> !short_err[5])
		else $error("short return did not restore status");

	chk_short_off: assert property (
		!short_en |=> short_err == 8'h00)
		else $error("short record kept with option off");

	chk_latch_block: assert property (
		clk_rise && le_block |=> $stable(out_latch) && $stable(cfg_latch))
		else $error("latch pin latched during mode switch");

	chk_mode_hold: assert property (
		!sw_decide |=> $stable(mode))
		else $error("mode changed outside a switch sequence");

	chk_gain_out: assert property (
		cfg_latch != gain_code |=> gain_code == $past(cfg_latch))
		else $error("gain code not following configuration latch");

	chk_latch_keep: assert property (
		!do_latch |=> $stable(out_latch) && $stable(cfg_latch))
		else $error("latch changed without latch pin");

	chk_special_hold: assert property (
		shift_hold && !err_load |=> $stable(shift_reg))
		else $error("serial input shifted while enable low");

	chk_special_shift: assert property (
		clk_rise && special && oe_n_s |=>
			shift_reg == {$past(shift_reg[6:0]), $past(sdi_s)})
		else $error("status not shifted out with enable high");

	chk_global_status: assert property (
		otg_s |=> err_status == 8'h00)
		else $error("global overtemperature not in every status bit");

	chk_chan_record: assert property (
		otc_s[2] && chan_on[2] |=> err_ot[2])
		else $error("channel overtemperature not recorded");

	chk_low_restart: assert property (
		clk_rise && oe_n_s |=> low_cnt == 2'b00)
		else $error("low sample count not restarted");

	cov_to_special: cover property (sw_decide && le_s);
	cov_err_read: cover property (err_load ##[1:300] (clk_rise && oe_n_s));
	cov_cfg_write: cover property (do_latch && special);
	cov_ot_restart: cover property (otg_s ##1 !otg_s [*3] ##1 |channel_sink);
	cov_short_seen: cover property (short_en && trig_s != 8'h00);
endmodule
`default_nettype wire

// File: sim/lssl_ctrl_model.sv
// System controller model driving the serial chain pins
`timescale 1ns/1ns
`default_nettype none
module lssl_ctrl_model (
	input  wire logic hclk,
	output logic      led_clk,
	output logic      serial_in,
	output logic      latch_mode_sel,
	output logic      out_en_n_mode
);
	initial begin
		led_clk        = 1'b0;
		serial_in      = 1'b0;
		latch_mode_sel = 1'b0;
		out_en_n_mode  = 1'b1;
	end
	////////////////////////////////////////////////////////////////////////////////
	// One rise, pins steady
	task automatic step(input logic d, input logic le, input logic oe);
		serial_in      <= d;
		latch_mode_sel <= le;
		out_en_n_mode  <= oe;
		repeat (4) @(posedge hclk);
		led_clk <= 1'b1;
		repeat (4) @(posedge hclk);
		led_clk   <= 1'b0;
		// Released data line shows inverse, not a stale bit
		serial_in <= ~d;
		@(posedge hclk);
	endtask
	task automatic byte_in(input logic [7:0] v, input logic le_last);
		for (int i = 7; i >= 0; i--) begin
			step(v[i], (i == 0) ? le_last : 1'b0, 1'b1);
		end
	endtask
	// Fixed settle covers sync and sink delay
	task automatic set_oe(input logic oe);
		out_en_n_mode <= oe;
		repeat (8) @(posedge hclk);
	endtask
endmodule
`default_nettype wire

// File: sim/lssl_tb_top.sv
// Self-checking bench for the LED sink shift and latch block
`timescale 1ns/1ns
`default_nettype none
module lssl_tb_top;
	import lssl_pkg::*;
	typedef struct packed {logic [7:0] data; logic [7:0] sink;} lssl_row_s;
	logic        hclk, hresetn, hsel, hwrite, hresp, hreadyout;
	logic [31:0] haddr, hwdata, hrdata, rd_val;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        led_clk, serial_in, latch_mode_sel, out_en_n_mode, ot_global, serial_out;
	logic [7:0]  cur_ok, short_trig, short_ret, ot_chan, channel_sink, gain_code;
	wire logic   hready;
	int          error_cnt;
	int          tests_run;
	lssl_row_s   rows [4];
	assign hready = hreadyout;
	lssl_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .led_clk(led_clk),
		.serial_in(serial_in), .latch_mode_sel(latch_mode_sel),
		.out_en_n_mode(out_en_n_mode), .cur_ok(cur_ok), .short_trig(short_trig),
		.short_ret(short_ret), .ot_global(ot_global), .ot_chan(ot_chan),
		.serial_out(serial_out), .channel_sink(channel_sink), .gain_code(gain_code));
	lssl_ctrl_model ctl (.hclk(hclk), .led_clk(led_clk), .serial_in(serial_in),
		.latch_mode_sel(latch_mode_sel), .out_en_n_mode(out_en_n_mode));
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Bounded wait: a stuck bus ends the run
	task automatic wait_rdy();
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && n < 50) begin
			n++;
			@(posedge hclk);
		end
		if (n >= 50) begin
			error_cnt++;
			summarize();
		end
	endtask
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		haddr  <= a;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		rd_val = hrdata;
	endtask
	task automatic msw(input logic le);
		ctl.step(1'b0, 1'b0, 1'b1);
		ctl.step(1'b0, 1'b0, 1'b0);
		ctl.step(1'b0, 1'b0, 1'b1);
		ctl.step(1'b0, le, 1'b1);
	endtask
	task automatic settle();
		repeat (8) @(posedge hclk);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		hresetn    = 1'b0;
		hsel       = 1'b0;
		haddr      = 32'h0;
		htrans     = 2'h0;
		hwrite     = 1'b0;
		hsize      = HSIZE_WORD;
		hwdata     = 32'h0;
		cur_ok     = 8'hb0;
		short_trig = 8'h00;
		short_ret  = 8'h00;
		ot_global  = 1'b0;
		ot_chan    = 8'h00;
		error_cnt  = 0;
		tests_run  = 0;
		rows       = '{'{8'h01, 8'h01}, '{8'ha5, 8'ha5}, '{8'h3c, 8'h3c}, '{8'hf0, 8'hf0}};
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		hsel    <= 1'b1;
		@(posedge hclk);
		ahb(1'b0, 32'(ADDR_STATUS), 32'h0);
		chk(rd_val, 32'h0);
		chk({16'h0, gain_code, channel_sink}, 32'h0);
		chk(32'({hresp, hreadyout}), 32'h1);
		ahb(1'b0, 32'h10, 32'h0);
		chk(rd_val, 32'h0);
		$display("Test reset done");
		foreach (rows[i]) begin
			ctl.byte_in(rows[i].data, 1'b1);
			ahb(1'b0, 32'(ADDR_SHIFT), 32'h0);
			chk(rd_val, 32'(rows[i].data));
			chk(32'(serial_out), 32'(rows[i].data[7]));
			ahb(1'b0, 32'(ADDR_STATUS), 32'h0);
			chk(32'(rd_val[15:8]), 32'(rows[i].data));
			ctl.set_oe(1'b0);
			chk(32'(channel_sink), 32'(rows[i].sink));
			ctl.set_oe(1'b1);
			chk(32'(channel_sink), 32'h0);
		end
		$display("Test normal rows done");
		msw(1'b1);
		ahb(1'b1, 32'(ADDR_STATUS), 32'h0);
		ahb(1'b0, 32'(ADDR_STATUS), 32'h0);
		chk(32'(rd_val[0]), 32'h1);
		ctl.byte_in(8'h5a, 1'b1);
		ahb(1'b0, 32'(ADDR_STATUS), 32'h0);
		chk(32'(gain_code), 32'h5a);
		chk(32'(rd_val[15:8]), 32'hf0);
		$display("Test special config done");
		// Third low sample loads status
		repeat (3) ctl.step(1'b0, 1'b0, 1'b0);
		ahb(1'b0, 32'(ADDR_SHIFT), 32'h0);
		chk(rd_val, 32'hb0);
		chk(32'(serial_out), 32'h1);
		chk(32'(channel_sink), 32'hf0);
		ahb(1'b1, 32'(ADDR_CTRL), 32'h1);
		short_trig <= 8'h20;
		settle();
		short_trig <= 8'h00;
		ahb(1'b0, 32'(ADDR_STATUS), 32'h0);
		chk(32'(rd_val[31:24]), 32'h90);
		short_ret <= 8'h20;
		settle();
		short_ret <= 8'h00;
		ahb(1'b0, 32'(ADDR_STATUS), 32'h0);
		chk(32'(rd_val[31:24]), 32'hb0);
		ot_chan <= 8'h80;
		settle();
		chk(32'(channel_sink), 32'h70);
		ot_chan <= 8'h00;
		settle();
		chk(32'(channel_sink), 32'hf0);
		ahb(1'b0, 32'(ADDR_STATUS), 32'h0);
		chk(32'(rd_val[31:24]), 32'h30);
		ot_global <= 1'b1;
		settle();
		chk(32'(channel_sink), 32'h0);
		ot_global <= 1'b0;
		settle();
		chk(32'(channel_sink), 32'hf0);
		ahb(1'b0, 32'(ADDR_STATUS), 32'h0);
		chk(32'(rd_val[31:24]), 32'h0);
		$display("Test error status done");
		ctl.set_oe(1'b1);
		msw(1'b0);
		ctl.set_oe(1'b0);
		ahb(1'b0, 32'(ADDR_STATUS), 32'h0);
		chk(32'(rd_val[0]), 32'h0);
		chk(32'(rd_val[31:24]), 32'hb0);
		$display("Test return normal done");
		summarize();
	end
endmodule
`default_nettype wire
